// [dv/afc_mac_tx_model.sv]
// mac transmitter model that serves pause requests between its own frames
`timescale 1ns/1ps
`default_nettype none
module afc_mac_tx_model import afc_pkg::*; (
  input  wire logic       sys_clk_in,
  input  wire logic       reset_n_in,
  input  wire afc_pause_t pause_in,
  output logic            tx_busy_out,
  output logic            pause_ack_out
);
  // ************************************************************
  // frame traffic and pause acceptance
  // ************************************************************
  int busy_left;
  always @(posedge sys_clk_in) begin
    if (!reset_n_in) begin
      tx_busy_out   <= 1'b0;
      pause_ack_out <= 1'b0;
      busy_left     <= 0;
    end else if (busy_left > 0) begin
      // a frame in flight is never cut short for a pause
      pause_ack_out <= 1'b0;
      busy_left     <= busy_left - 1;
      if (busy_left == 1) tx_busy_out <= 1'b0;
    end else if (pause_in.req && !pause_ack_out) begin
      pause_ack_out <= 1'b1;
    end else begin
      pause_ack_out <= 1'b0;
      if ($urandom_range(7) == 0) begin
        tx_busy_out <= 1'b1;
        busy_left   <= $urandom_range(30, 5);
      end
    end
  end
endmodule
`default_nettype wire

// [dv/testbench.sv]
// self-checking bench of the receive automatic flow controller
`timescale 1ns/1ps
`default_nettype none
module testbench import afc_pkg::*;;
  logic              clk, rst_n, rd, wr, fd, spd, busy, ack, jam, wreq;
  logic [3:0]        adr;
  logic [31:0]       wd, rdata;
  logic [13:0]       fill;
  afc_rx_evt_t       evt;
  afc_pause_t        pz;
  int                fail_count, num_checks, cyc, jcnt;
  int                jq[$];
  logic [31:0]       rq[$];
  logic [15:0]       pq[$];
  logic [15:0]       pv;
  int                jt[4] = '{100, 200, 300, 500};
  logic [4:0]        et[4] = '{5'h10, 5'h0C, 5'h0A, 5'h09};

  afc_flow_ctrl #(.JAM_STEP_CYCLES(10)) uut (
    .sys_clk_in(clk), .reset_n_in(rst_n), .ce_in(1'b1),
    .avs_address_in(adr), .avs_read_in(rd), .avs_write_in(wr),
    .avs_writedata_in(wd), .avs_byteenable_in(4'hF),
    .avs_readdata_out(rdata), .avs_waitrequest_out(wreq),
    .full_duplex_in(fd), .speed_100_in(spd), .rx_fill_in(fill),
    .rx_evt_in(evt), .tx_busy_in(busy), .pause_ack_in(ack),
    .pause_out(pz), .jam_out(jam));

  afc_mac_tx_model mac (
    .sys_clk_in(clk), .reset_n_in(rst_n), .pause_in(pz),
    .tx_busy_out(busy), .pause_ack_out(ack));

  // ************************************************************
  // clock, timeout and verdict
  // ************************************************************
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task give_verdict;
    if (fail_count == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  always @(posedge clk) begin
    cyc++;
    if (cyc == 60000) begin
      fail_count++;
      give_verdict();
    end
  end

  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      fail_count++;
      $display("[FAIL] %s exp %h got %h", n, e, g);
    end
  endtask

  task chk_jam(input int e, input int g);
    chk("jam_len", e, g);
  endtask

  task chk_pause(input logic [31:0] e, input logic [15:0] g);
    chk("pause_time", e, {16'h0000, g});
  endtask

  task chk_read(input logic [31:0] e, input logic [31:0] g);
    chk("readdata", e, g);
  endtask

  // ************************************************************
  // result watcher: oldest note against each result seen
  // ************************************************************
  always @(negedge clk) begin
    if (jam === 1'b1) jcnt++;
    else if (jcnt > 0) begin
      chk_jam(jq.size() ? jq.pop_front() : 0, jcnt);
      jcnt = 0;
    end
    if (pz.req === 1'b1 && ack === 1'b1)
      chk_pause(pq.size() ? pq.pop_front() : 32'hFFFFFFFF, pz.pause_time);
  end

  // read data taken at the rising edge that samples waitrequest low
  always @(posedge clk) begin
    if (rd === 1'b1 && wreq === 1'b0)
      chk_read(rq.size() ? rq.pop_front() : 32'hFFFFFFFF, rdata);
  end

  // ************************************************************
  // drivers
  // ************************************************************
  task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    rd  <= !w;
    wr  <= w;
    adr <= a;
    wd  <= d;
    if (!w) rq.push_back(d);
    @(posedge clk);
    while (wreq !== 1'b0) @(posedge clk);
    rd <= 1'b0;
    wr <= 1'b0;
  endtask

  task pulse(input logic [4:0] e);
    @(posedge clk);
    evt <= e;
    @(posedge clk);
    evt <= '0;
  endtask

  task jam_run(input int code, input int mode, input logic sp);
    logic [3:0] en;
    int         n;
    en = (mode == 0) ? 4'hF : 4'h1 << (4 - mode);
    n  = (code < 4) ? jt[code] : 10 * (code - 3);
    if (!sp) n += 44;
    bus(1'b1, 4'h0, {8'h00, 8'h02, 8'h01, 4'(code), en});
    spd  <= sp;
    fill <= 14'd128 + 14'((code == 0) ? 0 : $urandom_range(60));
    jq.push_back(n);
    pulse(et[mode]);
    @(negedge clk);
    while (jam !== 1'b0) @(negedge clk);
  endtask

  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    void'($urandom(16));
    {rst_n, rd, wr, fd, spd} = 5'h01;
    {adr, wd, fill, evt} = '0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    bus(1'b0, 4'h4, 32'h00000000);
    bus(1'b1, 4'hC, 32'hFFFFFFFF);
    bus(1'b0, 4'hC, 32'h00000000);
    for (int i = 0; i < 16; i++) jam_run(i, i % 4, i[2]);
    // just below the threshold an any-frame preamble may not jam
    bus(1'b1, 4'h0, 32'h00020101);
    fill <= 14'd127;
    pulse(5'h10);
    repeat (30) @(posedge clk);
    // full duplex: one pause at the crossing, zero time on the way down
    fd <= 1'b1;
    pv = 16'($urandom);
    bus(1'b1, 4'h4, {16'h0000, pv});
    bus(1'b0, 4'h4, {16'h0000, pv});
    bus(1'b1, 4'h0, 32'h00020151);
    bus(1'b0, 4'h0, 32'h00020151);
    pq.push_back(pv);
    fill <= 14'd128 + 14'($urandom_range(500));
    pulse(5'h10);
    repeat (300) @(posedge clk);
    // paused, nothing pending, no jam
    bus(1'b0, 4'h8, {2'b00, fill, 10'h000, spd, fd, 4'hC});
    pq.push_back(16'h0000);
    fill <= 14'd50;
    while (pq.size() != 0) @(posedge clk);
    repeat (50) @(posedge clk);
    // back to idle after the zero-time pause
    bus(1'b0, 4'h8, {2'b00, fill, 10'h000, spd, fd, 4'h0});
    give_verdict();
  end
endmodule
`default_nettype wire

// [hw/afc_flow_ctrl.sv]
// receive automatic flow controller with avalon-mm register slave
//
// Function
// - any-frame mode jams once threshold reached and a frame arrives, or pauses at threshold alone in full duplex
// - full-duplex flow control only with any-frame set and full-duplex link
// - half-duplex any-frame: no address check, jam at next valid preamble
// - full-duplex any-frame: request pause at once on reaching threshold
// - pause request held pending, sent when transmitter idle, never aborts
// - any-frame overrides multicast, broadcast and own-address selections
// - duration code picks jam time; 10 Mb/s adds 2.2 us
// - high threshold counts in 64-byte units of receive fill
// - one pause frame per crossing, carrying programmed pause time
// - jam lasts coded duration; code unused in full duplex
// - after a pause, send zero-time pause once fill drops below low
`timescale 1ns/1ps
`default_nettype none
`include "afc_params.svh"
module afc_flow_ctrl import afc_pkg::*; #(
  parameter int FILL_W          = 14,
  parameter int JAM_CNT_W       = 14,
  parameter int JAM_STEP_CYCLES = `AFC_JAM_STEP_CYC
) (
  input  wire logic              sys_clk_in,
  input  wire logic              reset_n_in,
  input  wire logic              ce_in,
  // avalon-mm slave
  input  wire logic [3:0]        avs_address_in,
  input  wire logic              avs_read_in,
  input  wire logic              avs_write_in,
  input  wire logic [31:0]       avs_writedata_in,
  input  wire logic [3:0]        avs_byteenable_in,
  output logic [31:0]            avs_readdata_out,
  output logic                   avs_waitrequest_out,
  // link and receive side
  input  wire logic              full_duplex_in,
  input  wire logic              speed_100_in,
  input  wire logic [FILL_W-1:0] rx_fill_in,
  input  wire afc_rx_evt_t       rx_evt_in,
  // mac transmit side
  input  wire logic              tx_busy_in,
  input  wire logic              pause_ack_in,
  output afc_pause_t             pause_out,
  output logic                   jam_out
);

  // ************************************************************
  // elaboration checks
  // ************************************************************
  if (FILL_W < 14) begin : g_fill_chk
    $error("fill width too small for 8-bit threshold in 64-byte units");
  end
  if (JAM_STEP_CYCLES * 12 + `AFC_JAM_EXTRA_CYC >= 2 ** JAM_CNT_W) begin : g_jam_chk
    $error("jam counter too narrow for longest duration");
  end
  if (JAM_STEP_CYCLES < 1) begin : g_step_chk
    $error("jam step must be at least one cycle");
  end

  // ************************************************************
  // declarations
  // ************************************************************
  afc_ctrl_t          ctrl;
  logic [15:0]        pause_time_value;
  logic               bus_ack;
  logic               bus_req;
  logic [31:0]        next_rdata;
  logic [31:0]        ctrl_merged;
  logic [31:0]        pause_merged;
  afc_fd_state_t      state;
  afc_fd_state_t      next_state;
  logic               fd_active;
  logic               hi_reached;
  logic               below_lo;
  logic [FILL_W-1:0]  hi_bytes;
  logic [FILL_W-1:0]  lo_bytes;
  logic               hd_frame_match;
  logic               hd_trig;
  logic               pause_load;
  logic [15:0]        pause_load_time;
  logic               pause_pending;
  logic               jam_active;
  logic [JAM_CNT_W-1:0] jam_count;

  // ************************************************************
  // avalon-mm slave: one wait cycle, then answer
  // ************************************************************
  function automatic logic [31:0] be_merge(input logic [31:0] old_v,
                                           input logic [31:0] new_v,
                                           input logic [3:0]  be);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        res[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return res;
  endfunction

  assign bus_req             = avs_read_in || avs_write_in;
  assign avs_waitrequest_out = bus_req && !bus_ack;

  always_ff @(posedge sys_clk_in) begin
    if (!reset_n_in) begin
      bus_ack <= 1'b0;
    end else if (ce_in) begin
      bus_ack <= bus_req && !bus_ack;
    end
  end

  always_comb begin
    next_rdata = 32'h00000000;
    unique case (avs_address_in)
      `AFC_REG_CTRL:   next_rdata = {8'h00, ctrl};
      `AFC_REG_PAUSE:  next_rdata = {16'h0000, pause_time_value};
      `AFC_REG_STATUS: begin
        next_rdata[`AFC_ST_JAM]                    = jam_active;
        next_rdata[`AFC_ST_PEND]                   = pause_pending;
        next_rdata[`AFC_ST_STATE_LSB +: 2]         = state;
        next_rdata[`AFC_ST_FD]                     = full_duplex_in;
        next_rdata[`AFC_ST_SPEED]                  = speed_100_in;
        next_rdata[`AFC_ST_FILL_LSB +: FILL_W]     = rx_fill_in;
      end
      default:         next_rdata = 32'h00000000;
    endcase
  end

  // read data captured in the wait cycle, stable on the answering edge
  always_ff @(posedge sys_clk_in) begin
    if (!reset_n_in) begin
      avs_readdata_out <= 32'h00000000;
    end else if (ce_in && avs_read_in && !bus_ack) begin
      avs_readdata_out <= next_rdata;
    end
  end

  assign ctrl_merged  = be_merge({8'h00, ctrl}, avs_writedata_in, avs_byteenable_in);
  assign pause_merged = be_merge({16'h0000, pause_time_value}, avs_writedata_in,
                                 avs_byteenable_in);

  always_ff @(posedge sys_clk_in) begin
    if (!reset_n_in) begin
      ctrl <= afc_ctrl_t'(`AFC_CTRL_RST);
    end else if (ce_in && avs_write_in && bus_ack && avs_address_in == `AFC_REG_CTRL) begin
      ctrl <= afc_ctrl_t'(ctrl_merged[23:0]);
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!reset_n_in) begin
      pause_time_value <= `AFC_PAUSE_RST;
    end else if (ce_in && avs_write_in && bus_ack && avs_address_in == `AFC_REG_PAUSE) begin
      pause_time_value <= pause_merged[15:0];
    end
  end

  // ************************************************************
  // thresholds
  // ************************************************************
  assign hi_bytes   = FILL_W'({ctrl.high_thr, {`AFC_UNIT_SHIFT{1'b0}}});
  assign lo_bytes   = FILL_W'({ctrl.low_thr, {`AFC_UNIT_SHIFT{1'b0}}});
  assign hi_reached = (rx_fill_in >= hi_bytes);
  assign below_lo   = (rx_fill_in < lo_bytes);
  assign fd_active  = ctrl.trigger_on_any_frame && full_duplex_in;

  // ************************************************************
  // half duplex: jam trigger
  // ************************************************************
  always_comb begin
    if (ctrl.trigger_on_any_frame) begin
      hd_frame_match = rx_evt_in.preamble;
    end else begin
      hd_frame_match = rx_evt_in.dest_valid &&
                       ((ctrl.trigger_on_multicast && rx_evt_in.dest_multicast) ||
                        (ctrl.trigger_on_broadcast && rx_evt_in.dest_broadcast) ||
                        (ctrl.trigger_on_own_address && rx_evt_in.dest_own));
    end
  end

  assign hd_trig = !full_duplex_in && hi_reached && hd_frame_match;

  afc_jam_timer #(
    .CNT_W        (JAM_CNT_W),
    .STEP_CYC     (JAM_STEP_CYCLES)
  ) u_jam (
    .sys_clk_in   (sys_clk_in),
    .reset_n_in   (reset_n_in),
    .ce_in        (ce_in),
    .start_in     (hd_trig),
    .code_in      (ctrl.jam_duration_code),
    .speed_100_in (speed_100_in),
    .active_out   (jam_active),
    .count_out    (jam_count)
  );

  assign jam_out = jam_active;

  // ************************************************************
  // full duplex: pause state machine
  // ************************************************************
  always_comb begin
    next_state      = state;
    pause_load      = 1'b0;
    pause_load_time = pause_time_value;
    unique case (state)
      AFC_IDLE: begin
        if (fd_active && hi_reached) begin
          pause_load = 1'b1;
          next_state = AFC_REQ_PAUSE;
        end
      end
      AFC_REQ_PAUSE: begin
        if (!pause_pending) begin
          next_state = AFC_PAUSED;
        end
      end
      AFC_PAUSED: begin
        if (!fd_active) begin
          next_state = AFC_IDLE;
        end else if (below_lo) begin
          pause_load      = 1'b1;
          pause_load_time = `AFC_ZERO_PAUSE;
          next_state      = AFC_REQ_RESUME;
        end
      end
      AFC_REQ_RESUME: begin
        if (!pause_pending) begin
          next_state = AFC_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk_in) begin
    if (!reset_n_in) begin
      state <= AFC_IDLE;
    end else if (ce_in) begin
      state <= next_state;
    end
  end

  afc_pause_queue u_pause (
    .sys_clk_in    (sys_clk_in),
    .reset_n_in    (reset_n_in),
    .ce_in         (ce_in),
    .load_in       (pause_load),
    .pause_time_in (pause_load_time),
    .tx_busy_in    (tx_busy_in),
    .ack_in        (pause_ack_in),
    .pause_out     (pause_out),
    .pending_out   (pause_pending)
  );

  // ************************************************************
  // assertions
  // ************************************************************
  any_jam_a: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    ce_in && ctrl.trigger_on_any_frame && !full_duplex_in && hi_reached &&
    rx_evt_in.preamble |=> jam_out && jam_count != '0)
    else $error("any-frame preamble above threshold did not start jam");
  fd_gate_a: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    ce_in && state == AFC_IDLE && !fd_active |=> state == AFC_IDLE && !pause_pending)
    else $error("pause started without full-duplex any-frame mode");
  preamble_act_a: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    ce_in && ctrl.trigger_on_any_frame && !full_duplex_in && hi_reached &&
    rx_evt_in.preamble && !rx_evt_in.dest_valid |-> hd_trig)
    else $error("any-frame jam waited for address decode");
  fd_pause_now_a: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    ce_in && state == AFC_IDLE && fd_active && hi_reached |=>
    state == AFC_REQ_PAUSE && pause_pending && pause_out.pause_time == $past(pause_time_value))
    else $error("threshold reached without immediate pause request");
  any_override_a: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    ctrl.trigger_on_any_frame && !rx_evt_in.preamble |-> !hd_trig)
    else $error("selective trigger acted while any-frame set");
  hi_units_a: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    ce_in && state == AFC_IDLE && fd_active &&
    {2'b00, rx_fill_in} < {ctrl.high_thr, 8'h00} >> 2 |=> state == AFC_IDLE)
    else $error("pause before fill reached 64-byte threshold");
  one_pause_a: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    ce_in && state == AFC_PAUSED && fd_active && !below_lo |=>
    state == AFC_PAUSED && !pause_pending)
    else $error("second pause frame in one crossing");
  fd_no_jam_a: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    full_duplex_in |-> !hd_trig)
    else $error("jam started in full duplex");
  resume_zero_a: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    ce_in && state == AFC_PAUSED && fd_active && below_lo |=>
    state == AFC_REQ_RESUME ##0 pause_out.pause_time == 16'h0000 && pause_pending)
    else $error("no zero-time pause after fill fell below low");

  jam_seen_c:     cover property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    $rose(jam_out));
  pause_cycle_c:  cover property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    state == AFC_PAUSED ##[1:1000] state == AFC_REQ_RESUME ##[1:1000] state == AFC_IDLE);
  deferred_tx_c:  cover property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    pause_pending && tx_busy_in ##1 pause_out.req);
  bus_write_c:    cover property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    avs_write_in && !avs_waitrequest_out);

endmodule
`default_nettype wire

// [hw/afc_jam_timer.sv]
// half-duplex backpressure duration timer
`timescale 1ns/1ps
`default_nettype none
`include "afc_params.svh"
module afc_jam_timer import afc_pkg::*; #(
  parameter int CNT_W     = 14,
  parameter int STEP_CYC  = `AFC_JAM_STEP_CYC
) (
  input  wire logic             sys_clk_in,
  input  wire logic             reset_n_in,
  input  wire logic             ce_in,
  input  wire logic             start_in,
  input  wire logic [3:0]       code_in,
  input  wire logic             speed_100_in,
  output logic                  active_out,
  output logic [CNT_W-1:0]      count_out
);

  logic [CNT_W-1:0] count;
  logic [CNT_W-1:0] next_load;

  // ************************************************************
  // duration lookup
  // ************************************************************
  function automatic int jam_cycles(input logic [3:0] code, input logic fast);
    int base;
    unique case (code)
      4'h0:    base = `AFC_JAM_T0_CYC;
      4'h1:    base = `AFC_JAM_T1_CYC;
      4'h2:    base = `AFC_JAM_T2_CYC;
      4'h3:    base = `AFC_JAM_T3_CYC;
      default: base = STEP_CYC * (int'(code) - `AFC_JAM_STEP_BASE);
    endcase
    return fast ? base : base + `AFC_JAM_EXTRA_CYC;
  endfunction

  assign next_load = CNT_W'(jam_cycles(code_in, speed_100_in));

  // ************************************************************
  // counter
  // ************************************************************
  always_ff @(posedge sys_clk_in) begin
    if (!reset_n_in) begin
      count <= '0;
    end else if (ce_in) begin
      if (start_in) begin
        count <= next_load;
      end else if (count != '0) begin
        count <= count - CNT_W'(1);
      end
    end
  end

  assign active_out = (count != '0);
  assign count_out  = count;

  jam_load_a: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    ce_in && start_in && code_in == 4'h0 && speed_100_in |=> count == CNT_W'(100))
    else $error("jam code 0 at 100M did not load 5 us");
  jam_slow_a: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    ce_in && start_in && code_in == 4'h0 && !speed_100_in |=> count == CNT_W'(144))
    else $error("jam code 0 at 10M did not load 7.2 us");

endmodule
`default_nettype wire

// [hw/afc_params.svh]
// constants of the receive automatic flow controller
`ifndef AFC_PARAMS_SVH
`define AFC_PARAMS_SVH

// ************************************************************
// register byte offsets
// ************************************************************
`define AFC_REG_CTRL        4'h0
`define AFC_REG_PAUSE       4'h4
`define AFC_REG_STATUS      4'h8

// ************************************************************
// reset values and the zero pause time
// ************************************************************
`define AFC_CTRL_RST        24'h000000
`define AFC_PAUSE_RST       16'h0000
`define AFC_ZERO_PAUSE      16'h0000

// ************************************************************
// status register field positions
// ************************************************************
`define AFC_ST_JAM          0
`define AFC_ST_PEND         1
`define AFC_ST_STATE_LSB    2
`define AFC_ST_FD           4
`define AFC_ST_SPEED        5
`define AFC_ST_FILL_LSB     16

// ************************************************************
// threshold unit: 64 bytes
// ************************************************************
`define AFC_UNIT_SHIFT      6

// ************************************************************
// jam durations, times in ns, counts in cycles
// ************************************************************
`define AFC_CLK_PERIOD_NS   50
`define AFC_JAM_T0_NS       5000
`define AFC_JAM_T1_NS       10000
`define AFC_JAM_T2_NS       15000
`define AFC_JAM_T3_NS       25000
`define AFC_JAM_STEP_NS     50000
`define AFC_JAM_10M_EXTRA_NS 2200
`define AFC_NS_TO_CYC(ns)   (((ns) + `AFC_CLK_PERIOD_NS - 1) / `AFC_CLK_PERIOD_NS)
`define AFC_JAM_T0_CYC      `AFC_NS_TO_CYC(`AFC_JAM_T0_NS)
`define AFC_JAM_T1_CYC      `AFC_NS_TO_CYC(`AFC_JAM_T1_NS)
`define AFC_JAM_T2_CYC      `AFC_NS_TO_CYC(`AFC_JAM_T2_NS)
`define AFC_JAM_T3_CYC      `AFC_NS_TO_CYC(`AFC_JAM_T3_NS)
`define AFC_JAM_STEP_CYC    `AFC_NS_TO_CYC(`AFC_JAM_STEP_NS)
`define AFC_JAM_EXTRA_CYC   `AFC_NS_TO_CYC(`AFC_JAM_10M_EXTRA_NS)
`define AFC_JAM_STEP_BASE   3
`define AFC_JAM_CODE_MAX    15

`endif

// [hw/afc_pause_queue.sv]
// pending pause frame request held until the transmitter is free
`timescale 1ns/1ps
`default_nettype none
`include "afc_params.svh"
module afc_pause_queue import afc_pkg::*; (
  input  wire logic        sys_clk_in,
  input  wire logic        reset_n_in,
  input  wire logic        ce_in,
  input  wire logic        load_in,
  input  wire logic [15:0] pause_time_in,
  input  wire logic        tx_busy_in,
  input  wire logic        ack_in,
  output afc_pause_t       pause_out,
  output logic             pending_out
);

  logic        pending;
  logic [15:0] held_time;

  // ************************************************************
  // pending flag, load wins over ack
  // ************************************************************
  always_ff @(posedge sys_clk_in) begin
    if (!reset_n_in) begin
      pending <= 1'b0;
    end else if (ce_in) begin
      if (load_in) begin
        pending <= 1'b1;
      end else if (ack_in && pause_out.req) begin
        pending <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!reset_n_in) begin
      held_time <= `AFC_PAUSE_RST;
    end else if (ce_in && load_in) begin
      held_time <= pause_time_in;
    end
  end

  // offered only between frames so a running transmission is never cut
  assign pause_out.req        = pending && !tx_busy_in;
  assign pause_out.pause_time = held_time;
  assign pending_out          = pending;

  no_abort_a: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    tx_busy_in |-> !pause_out.req)
    else $error("pause offered while transmitter busy");
  hold_pend_a: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    ce_in && pending && !(ack_in && pause_out.req) |=> pending)
    else $error("pause request dropped before acceptance");

endmodule
`default_nettype wire

// [hw/afc_pkg.sv]
// types of the receive automatic flow controller
package afc_pkg;

  // control word, laid out as in the control register
  typedef struct packed {
    logic [7:0] high_thr;
    logic [7:0] low_thr;
    logic [3:0] jam_duration_code;
    logic       trigger_on_multicast;
    logic       trigger_on_broadcast;
    logic       trigger_on_own_address;
    logic       trigger_on_any_frame;
  } afc_ctrl_t;

  // receive-side events, one-cycle pulses from the receive mac
  typedef struct packed {
    logic preamble;
    logic dest_valid;
    logic dest_multicast;
    logic dest_broadcast;
    logic dest_own;
  } afc_rx_evt_t;

  // pause frame request towards the mac transmitter
  typedef struct packed {
    logic        req;
    logic [15:0] pause_time;
  } afc_pause_t;

  typedef enum logic [1:0] {
    AFC_IDLE       = 2'b00,
    AFC_REQ_PAUSE  = 2'b01,
    AFC_PAUSED     = 2'b11,
    AFC_REQ_RESUME = 2'b10
  } afc_fd_state_t;

endpackage
